// ===== oscsg_defs.svh
`ifndef OSCSG_DEFS_SVH
`define OSCSG_DEFS_SVH
`define OSCSG_ADDR_STOP_KEY  8'hed
`define OSCSG_ADDR_OSC_CTRL  8'hfa
`define OSCSG_ADDR_CLK_DIV   8'hd4
`define OSCSG_STOP_KEY       8'ha5
`define OSCSG_BIT_SEL        0
`define OSCSG_BIT_SUB_STOP   2
`define OSCSG_BIT_MAIN_STOP  3
`define OSCSG_DIV_LO         3
`define OSCSG_DIV_HI         4
`define OSCSG_BIT_WAKE       7
`define OSCSG_DIV_16         2'h0
`define OSCSG_DIV_8          2'h1
`define OSCSG_DIV_2          2'h2
`define OSCSG_DIV_1          2'h3
`define OSCSG_CNT_16         4'hf
`define OSCSG_CNT_8          4'h7
`define OSCSG_CNT_2          4'h1
`define OSCSG_CNT_1          4'h0
`define OSCSG_CNT_ZERO       4'h0
`define OSCSG_CNT_STEP       4'h1
`define OSCSG_KEY_CLR        8'h00
`endif

// ===== oscsg_pkg.sv
package oscsg_pkg;
  typedef enum logic [1:0] {
    oscsg_run_s   = 2'h0,
    oscsg_stop_s  = 2'h1,
    oscsg_reset_s = 2'h3
  } oscsg_mode_t;

  typedef struct packed {
    logic        sel;
    logic        main_stop;
    logic        sub_stop;
    logic [1:0]  div;
    logic        wake_ctl;
    logic [7:0]  key;
    oscsg_mode_t mode;
    logic [7:0]  rdata;
    logic        sys_rst;
    logic [3:0]  div_cnt;
    logic        cpu_en;
    logic        main_run;
    logic        sub_run;
    logic        stop_flag;
    logic        wake_s1;
    logic        wake_s2;
  } oscsg_state_t;
endpackage : oscsg_pkg

// ===== oscsg_top.sv
`timescale 1ns/1ps
`include "oscsg_defs.svh"
// Functional notes
// RQ1: bit 0 selects main or sub clock
// RQ2: bit 3 set stops main oscillator
// RQ3: bit 2 set stops sub oscillator
// RQ4: reset clears select and both stop bits
// RQ5: unused control bits read as zero
// RQ6: stop allowed only with key a5
// RQ7: stop without key raises system reset
// RQ8: reset clears the stop key register
// RQ9: divider field divides by 1,2,8,16
// RQ10: software keeps divide-by-1 on sub clock
// RQ11: software order: divider, select, main stop
// RQ12: software restarts main before reselecting it
// RQ13: software waits about 16 ms between steps
// RQ14: registers reached by direct register address only
// RQ15: stop halts main; reset or interrupt restarts
// RQ16: clock select switches without glitched pulses
module oscsg_top
  import oscsg_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // direct register port, register addressing only
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // cpu events
  input  wire logic       stop_exec,
  input  wire logic       ext_wake_irq,
  // oscillator and clock control
  output logic            main_osc_run,
  output logic            sub_osc_run,
  output logic            sub_selected,
  output logic            cpu_clk_en,
  output logic            in_stop,
  output logic            stop_reset_req
);

  // whole state of the block, registered once per clock
  oscsg_state_t s_r;
  oscsg_state_t s_nxt;

  // reset image; both oscillators come up running on the main clock
  localparam oscsg_state_t rst_val = '{
    sel:       1'b0,
    main_stop: 1'b0,
    sub_stop:  1'b0,
    div:       `OSCSG_DIV_16,
    wake_ctl:  1'b0,
    key:       `OSCSG_KEY_CLR,
    mode:      oscsg_run_s,
    rdata:     '0,
    sys_rst:   1'b0,
    div_cnt:   `OSCSG_CNT_ZERO,
    cpu_en:    1'b0,
    main_run:  1'b1,
    sub_run:   1'b1,
    stop_flag: 1'b0,
    wake_s1:   1'b0,
    wake_s2:   1'b0
  };

  always_comb begin
    logic [3:0] limit;
    limit = `OSCSG_CNT_16;
    s_nxt = s_r;

    // pulses and read data last one cycle unless set again
    s_nxt.sys_rst = 1'b0;
    s_nxt.rdata   = '0;

    // two flops before anything reads the wake pin
    s_nxt.wake_s1 = ext_wake_irq;
    s_nxt.wake_s2 = s_r.wake_s1;

    if (reg_wr) begin // see RQ14
      unique case (reg_addr)
        `OSCSG_ADDR_OSC_CTRL: begin
          s_nxt.sel       = reg_wdata[`OSCSG_BIT_SEL];       // see RQ1
          s_nxt.main_stop = reg_wdata[`OSCSG_BIT_MAIN_STOP]; // see RQ2
          s_nxt.sub_stop  = reg_wdata[`OSCSG_BIT_SUB_STOP];  // see RQ3
        end
        `OSCSG_ADDR_STOP_KEY: begin
          s_nxt.key = reg_wdata;
        end
        `OSCSG_ADDR_CLK_DIV: begin
          s_nxt.div      = reg_wdata[`OSCSG_DIV_HI:`OSCSG_DIV_LO]; // see RQ9
          s_nxt.wake_ctl = reg_wdata[`OSCSG_BIT_WAKE];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `OSCSG_ADDR_OSC_CTRL: begin
          s_nxt.rdata[`OSCSG_BIT_SEL]       = s_r.sel; // see RQ5
          s_nxt.rdata[`OSCSG_BIT_SUB_STOP]  = s_r.sub_stop;
          s_nxt.rdata[`OSCSG_BIT_MAIN_STOP] = s_r.main_stop;
        end
        `OSCSG_ADDR_STOP_KEY: begin
          s_nxt.rdata = s_r.key;
        end
        `OSCSG_ADDR_CLK_DIV: begin
          s_nxt.rdata[`OSCSG_DIV_HI:`OSCSG_DIV_LO] = s_r.div;
          s_nxt.rdata[`OSCSG_BIT_WAKE]             = s_r.wake_ctl;
        end
        default: begin
        end
      endcase
    end
    unique case (s_r.mode)
      oscsg_run_s: begin
        if (stop_exec) begin
          if (s_r.key == `OSCSG_STOP_KEY) begin // see RQ6
            s_nxt.mode = oscsg_stop_s;
          end else begin
            s_nxt.mode    = oscsg_reset_s; // see RQ7
            s_nxt.sys_rst = 1'b1;
          end
        end
      end
      oscsg_stop_s: begin
        if (s_r.wake_s2) begin // see RQ15
          s_nxt.mode = oscsg_run_s;
        end
      end
      oscsg_reset_s: begin
        // a refused stop returns the clock registers to their reset values
        s_nxt.mode      = oscsg_run_s;
        s_nxt.sel       = rst_val.sel; // see RQ4
        s_nxt.main_stop = rst_val.main_stop;
        s_nxt.sub_stop  = rst_val.sub_stop;
        s_nxt.key       = rst_val.key; // see RQ8
        s_nxt.div       = rst_val.div;
        s_nxt.wake_ctl  = rst_val.wake_ctl;
      end
      default: begin
        s_nxt.mode = oscsg_run_s;
      end
    endcase
    unique case (s_r.div)
      `OSCSG_DIV_16: limit = `OSCSG_CNT_16;
      `OSCSG_DIV_8:  limit = `OSCSG_CNT_8;
      `OSCSG_DIV_2:  limit = `OSCSG_CNT_2;
      `OSCSG_DIV_1:  limit = `OSCSG_CNT_1;
    endcase
    // enable pulses once per period; a divider change applies at once and can shorten the current one
    if (s_r.mode == oscsg_stop_s) begin
      s_nxt.cpu_en  = 1'b0;
      s_nxt.div_cnt = `OSCSG_CNT_ZERO;
    end else if (s_r.div_cnt >= limit) begin // see RQ9
      s_nxt.cpu_en  = 1'b1;
      s_nxt.div_cnt = `OSCSG_CNT_ZERO;
    end else begin
      s_nxt.cpu_en  = 1'b0;
      s_nxt.div_cnt = s_r.div_cnt + `OSCSG_CNT_STEP;
    end

    // status copies, so every output leaves a flip-flop
    s_nxt.main_run  = !s_nxt.main_stop && (s_nxt.mode != oscsg_stop_s); // see RQ2 see RQ15
    s_nxt.sub_run   = !s_nxt.sub_stop; // see RQ3
    s_nxt.stop_flag = (s_nxt.mode == oscsg_stop_s);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_r <= rst_val; // see RQ4 see RQ8
    end else begin
      s_r <= s_nxt;
    end
  end

  // the select bit is only registered; the downstream mux retimes it on both clocks
  assign reg_rdata      = s_r.rdata;
  assign main_osc_run   = s_r.main_run; // see RQ15
  assign sub_osc_run    = s_r.sub_run;
  assign sub_selected   = s_r.sel; // see RQ16
  assign cpu_clk_en     = s_r.cpu_en;
  assign in_stop        = s_r.stop_flag;
  assign stop_reset_req = s_r.sys_rst;

endmodule : oscsg_top

// ===== oscsg_chk.sv
`timescale 1ns/1ps
module oscsg_chk (
  // watched ports
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       stop_exec,
  input wire logic       main_osc_run,
  input wire logic       sub_osc_run,
  input wire logic       sub_selected,
  input wire logic       in_stop,
  input wire logic       stop_reset_req
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire ctl_wr = reg_wr && reg_addr == 8'hfa && !stop_exec && !stop_reset_req && !in_stop;
  chk_sel_follow: assert property (ctl_wr |=> sub_selected == $past(reg_wdata[0]))
    else $error("select");
  chk_main_stop: assert property (ctl_wr |=> main_osc_run == !$past(reg_wdata[3]))
    else $error("main stop");
  chk_sub_stop: assert property (ctl_wr |=> sub_osc_run == !$past(reg_wdata[2]))
    else $error("sub stop");
  chk_unused_zero: assert property (reg_rd && reg_addr == 8'hfa |=> (reg_rdata & 8'hf2) == 8'h0)
    else $error("unused bits");
  chk_stop_taken: assert property (stop_exec && !in_stop |=> in_stop != stop_reset_req)
    else $error("stop");
  chk_bad_clear: assert property (stop_reset_req |=> !sub_selected && main_osc_run && !in_stop)
    else $error("bad stop");
  chk_stop_halt: assert property (in_stop |-> !main_osc_run)
    else $error("halt");
  chk_sel_steady: assert property ($changed(sub_selected) |-> $past(reg_wr) || $past(stop_reset_req))
    else $error("select change");
endmodule : oscsg_chk
bind oscsg_top oscsg_chk u_chk (.*);

// ===== oscsg_top_tb_top.sv
`timescale 1ns/1ps
module oscsg_top_tb_top;
  logic       clock, nrst, reg_wr, reg_rd, stop_exec, ext_wake_irq, rd_d;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic       main_osc_run, sub_osc_run, sub_selected, cpu_clk_en, in_stop, stop_reset_req;
  logic [7:0] exp_q[$];
  int         num_errors, check_count, cyc, n;
  wire  [7:0] osc = {5'h0, sub_selected, main_osc_run, sub_osc_run};
  oscsg_top u_dut (.*);
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  task chk(input string nm, input logic [7:0] s, e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task wr(input logic [7:0] a, v);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1;
    @(negedge clock);
    reg_wr = 0;
  endtask : wr
  task rd(input logic [7:0] a, e);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1;
    exp_q.push_back(e);
    @(negedge clock);
    reg_rd = 0;
  endtask : rd
  // load key then pulse the stop instruction
  task stop(input logic [7:0] k);
    wr(8'hed, k);
    stop_exec = 1;
    @(negedge clock);
    stop_exec = 0;
  endtask : stop
  always @(posedge clock) rd_d <= reg_rd;
  always @(negedge clock) begin
    if (rd_d) chk("rdata", reg_rdata, exp_q.pop_front());
    cyc++;
    if (cyc > 3000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    {nrst, reg_wr, reg_rd, stop_exec, ext_wake_irq, reg_addr, reg_wdata} = '0;
    d = $urandom(35219);
    repeat (20) @(negedge clock);
    nrst = 1;
    chk("osc", osc, 8'h03);
    rd(8'hfa, 8'h00);
    rd(8'hed, 8'h00);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00);
    $display("reset test done");
    wr(8'hd4, 8'h18);
    for (n = 0; n < 6; n++) begin
      d = $urandom;
      wr(8'hfa, d);
      rd(8'hfa, d & 8'h0d);
      chk("osc", osc, {5'h0, d[0], !d[3], !d[2]});
    end
    wr(8'hfa, 8'h00);
    $display("control test done");
    for (n = 0; n < 4; n++) begin
      wr(8'hd4, {3'h0, n[1:0], 3'h0});
      repeat (16) @(negedge clock);
      d = 0;
      repeat (32) @(negedge clock) d += cpu_clk_en;
      chk("div", d, 8'(32 >> (n == 0 ? 4 : n == 1 ? 3 : n == 2 ? 1 : 0)));
    end
    wr(8'hd4, 8'h18);
    wr(8'hfa, 8'h01);
    repeat (16) @(negedge clock);
    wr(8'hfa, 8'h09);
    chk("osc", osc, 8'h05);
    wr(8'hfa, 8'h01);
    repeat (16) @(negedge clock);
    wr(8'hfa, 8'h00);
    chk("osc", osc, 8'h03);
    $display("switch test done");
    stop(8'ha5);
    repeat (2) @(negedge clock);
    chk("stop", {6'h0, in_stop, main_osc_run}, 8'h02);
    ext_wake_irq = 1;
    for (n = 0; n < 20 && in_stop; n++) @(negedge clock);
    ext_wake_irq = 0;
    chk("wake", {7'h0, in_stop}, 8'h00);
    wr(8'hfa, 8'h01);
    stop(8'ha4);
    chk("req", {6'h0, stop_reset_req, in_stop}, 8'h02);
    rd(8'hed, 8'h00);
    rd(8'hfa, 8'h00);
    $display("stop test done");
    wrap_up();
  end
endmodule : oscsg_top_tb_top
